// ==== bms_pkg.sv ====
// Shared constants and types for the battery mode sequencer
package bms_pkg;

   // ==========================================================
   // Operating modes
   typedef enum logic [1:0] {
      BMS_MISSION,                       // System power, PLL stable
      BMS_BROWNOUT,                      // Battery, MPU running
      BMS_DISPLAY,                       // Battery, display only
      BMS_SLEEP                          // Battery, deepest state
   } bms_mode_t;

   // ==========================================================
   // Timing
   localparam int unsigned CLK_MHZ     = 200;    // sys_clk rate
   localparam int unsigned SETTLE_NS   = 1000;   // Supply must stay good this long
   localparam int unsigned SETTLE_CYC  = (SETTLE_NS * CLK_MHZ + 999) / 1000;

   // ==========================================================
   // Register indices (byte address is four times the index)
   localparam logic [13:0] IDX_CLKCFG  = 14'h28b0; // Clock configuration
   localparam logic [13:0] IDX_CTRL    = 14'h28b2; // Mode requests
   localparam logic [13:0] IDX_STATUS  = 14'h28b3; // Mode and supply state
   localparam logic [13:0] IDX_WAKE    = 14'h28b4; // Sticky event causes
   localparam logic [13:0] IDX_MASK    = 14'h28b5; // Interrupt mask

   // ==========================================================
   // Field positions
   localparam int CLK_PLL_FAST_BIT     = 0;      // PLL fast/slow select
   localparam int CTRL_DISP_BIT        = 6;      // Display-only request
   localparam int CTRL_SLEEP_BIT       = 7;      // Sleep request
   localparam int STAT_MODE_LSB        = 0;      // Mode field, two bits
   localparam int STAT_GOOD_BIT        = 2;      // Supply-good flag
   localparam int STAT_LOCK_BIT        = 3;      // PLL lock
   localparam int EV_TIMER             = 0;      // Wake-up timer timeout
   localparam int EV_BUTTON            = 1;      // Pushbutton pressed
   localparam int EV_PIN_A             = 2;      // Wake pin a rising
   localparam int EV_PIN_B             = 3;      // Wake pin b rising
   localparam int EV_PIN_C             = 4;      // Wake pin c rising
   localparam int EV_SERIAL            = 5;      // Serial receive activity
   localparam int EV_OPTICAL           = 6;      // Optical receive activity
   localparam int EV_SUPPLY_LOST       = 7;      // Forced into brownout
   localparam int EV_SUPPLY_BACK       = 8;      // Returned to mission
   localparam int WAKE_W               = 7;      // Pin wake sources
   localparam int EV_W                 = 9;      // All event bits

   // ==========================================================
   // Reset values
   localparam logic       CLK_PLL_FAST_RST = 1'b1;
   localparam logic [8:0] MASK_RST         = 9'h000;

endpackage : bms_pkg

// ==== bms_supply_monitor.sv ====
// Supply comparator qualification into the supply-good flag
`timescale 1ns/1ps
module bms_supply_monitor #(
   parameter int unsigned SETTLE = bms_pkg::SETTLE_CYC
) (
   input  wire logic sys_clk,
   input  wire logic sys_rst,
   input  wire logic supply_below_threshold,
   output logic      supply_good_flag
);

   // ==========================================================
   // Settle counter
   logic [15:0] settle_reg;              // Cycles of continuous good supply

   // Counts good cycles, restarts on any dip
   always_ff @(posedge sys_clk) begin
      if (sys_rst || supply_below_threshold) begin
         settle_reg <= 16'h0000;
      end else if (settle_reg != 16'(SETTLE)) begin
         settle_reg <= settle_reg + 16'h0001;
      end
   end

   // Flag drops at once on a dip, rises only after settling
   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         supply_good_flag <= 1'b0;
      end else if (supply_below_threshold) begin
         supply_good_flag <= 1'b0;
      end else if (settle_reg == 16'(SETTLE)) begin
         supply_good_flag <= 1'b1;
      end
   end

   a_flag_clears: assert property (@(posedge sys_clk) disable iff (sys_rst)
      supply_below_threshold |=> !supply_good_flag)
      else $error("supply flag not cleared after comparator trip");

endmodule : bms_supply_monitor

// ==== bms_wake_detect.sv ====
// Wake source edge and activity detection
`timescale 1ns/1ps
module bms_wake_detect (
   input  wire logic       sys_clk,
   input  wire logic       sys_rst,
   input  wire logic       wake_timer_expired,
   input  wire logic       pushbutton_input,
   input  wire logic       wake_pin_a,
   input  wire logic       wake_pin_b,
   input  wire logic       wake_pin_c,
   input  wire logic       serial_rx_pin,
   input  wire logic       optical_receive_pin,
   output logic [6:0]      wake_events
);

   // ==========================================================
   // Previous samples
   logic [6:0] now_w;                    // Current input levels
   logic [6:0] prev_reg;                 // Last cycle's levels

   assign now_w = {optical_receive_pin, serial_rx_pin, wake_pin_c, wake_pin_b,
                   wake_pin_a, pushbutton_input, wake_timer_expired};

   // Keeps last levels; idle receive lines rest high
   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         prev_reg <= 7'h60;
      end else begin
         prev_reg <= now_w;
      end
   end

   // Rising edges for level sources, any edge for receive lines
   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         wake_events <= 7'h00;
      end else begin
         wake_events[4:0] <= now_w[4:0] & ~prev_reg[4:0];
         wake_events[6:5] <= now_w[6:5] ^ prev_reg[6:5];
      end
   end

   a_pin_rise: assert property (@(posedge sys_clk) disable iff (sys_rst)
      $rose(wake_pin_a) |=> wake_events[bms_pkg::EV_PIN_A])
      else $error("wake pin edge not reported");

   a_rx_activity: assert property (@(posedge sys_clk) disable iff (sys_rst)
      $changed(optical_receive_pin) ##1 !$past(sys_rst, 2)
      |-> wake_events[bms_pkg::EV_OPTICAL])
      else $error("optical receive activity not reported");

endmodule : bms_wake_detect

// ==== bms_sequencer.sv ====
// Battery operating-mode sequencer with APB register access
//
// Register access over APB and the register addresses were chosen for this implementation.
`timescale 1ns/1ps

module bms_sequencer (
   input  wire logic        sys_clk,
   input  wire logic        sys_rst,
   // APB slave
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [15:0] paddr,
   input  wire logic [31:0] pwdata,
   output logic [31:0]      prdata,
   output logic             pready,
   output logic             pslverr,
   // Supply, clock and wake sources
   input  wire logic        supply_below_threshold,
   input  wire logic        pll_locked,
   input  wire logic        wake_timer_expired,
   input  wire logic        pushbutton_input,
   input  wire logic        wake_pin_a,
   input  wire logic        wake_pin_b,
   input  wire logic        wake_pin_c,
   input  wire logic        serial_rx_pin,
   input  wire logic        optical_receive_pin,
   // Mode and power controls
   output logic [1:0]       mode,
   output logic             system_domain_enable,
   output logic             battery_supply_select,
   output logic             pll_enable,
   output logic             pll_fast,
   output logic             mpu_run,
   output logic             display_enable,
   output logic             irq
);

   // ==========================================================
   // Declarations
   bms_pkg::bms_mode_t       mode_reg;            // Current mode
   bms_pkg::bms_mode_t       mode_next;           // Next mode
   logic                     supply_good_flag;    // Qualified supply
   logic [6:0]               wake_events;         // Pin wake pulses
   logic                     disp_req_reg;        // Display-only request
   logic                     sleep_req_reg;       // Sleep request
   logic                     pll_fast_reg;        // PLL speed select
   logic [8:0]               wake_stat_reg;       // Sticky causes
   logic [8:0]               wake_stat_next;      // Sticky causes, next
   logic [8:0]               mask_reg;            // Interrupt mask
   logic [8:0]               ev_w;                // Events this cycle
   logic                     low_mode_w;          // Display or sleep
   logic                     setup_w;             // APB setup phase
   logic                     wr_w;                // APB write completes
   logic [31:0]              rd_value;            // Read mux
   logic                     mapped;              // Address decodes

   // Matches a byte address against a register index
   function automatic logic addr_is(input logic [15:0] a, input logic [13:0] idx);
      addr_is = (a == {idx, 2'b00});
   endfunction : addr_is

   // ==========================================================
   // Sub-blocks
   bms_supply_monitor u_supply (
      .sys_clk                (sys_clk),
      .sys_rst                (sys_rst),
      .supply_below_threshold (supply_below_threshold),
      .supply_good_flag       (supply_good_flag)
   );

   bms_wake_detect u_wake (
      .sys_clk             (sys_clk),
      .sys_rst             (sys_rst),
      .wake_timer_expired  (wake_timer_expired),
      .pushbutton_input    (pushbutton_input),
      .wake_pin_a          (wake_pin_a),
      .wake_pin_b          (wake_pin_b),
      .wake_pin_c          (wake_pin_c),
      .serial_rx_pin       (serial_rx_pin),
      .optical_receive_pin (optical_receive_pin),
      .wake_events         (wake_events)
   );

   // ==========================================================
   // Mode sequencing
   assign low_mode_w = (mode_reg == bms_pkg::BMS_DISPLAY) ||
                       (mode_reg == bms_pkg::BMS_SLEEP);

   // Next mode from supply, requests and wake events
   always_comb begin
      mode_next = mode_reg;
      case (mode_reg)
         bms_pkg::BMS_MISSION: begin
            if (!supply_good_flag) begin
               mode_next = bms_pkg::BMS_BROWNOUT;
            end else if (disp_req_reg) begin
               mode_next = bms_pkg::BMS_DISPLAY;
            end
         end
         bms_pkg::BMS_BROWNOUT: begin
            if (supply_good_flag && pll_locked) begin
               mode_next = bms_pkg::BMS_MISSION;
            end else if (sleep_req_reg) begin
               mode_next = bms_pkg::BMS_SLEEP;
            end else if (disp_req_reg) begin
               mode_next = bms_pkg::BMS_DISPLAY;
            end
         end
         bms_pkg::BMS_DISPLAY, bms_pkg::BMS_SLEEP: begin
            if (supply_good_flag && pll_locked) begin
               mode_next = bms_pkg::BMS_MISSION;
            end else if (|wake_events) begin
               mode_next = bms_pkg::BMS_BROWNOUT;
            end
         end
         default: begin
            mode_next = bms_pkg::BMS_BROWNOUT;
         end
      endcase
   end

   // Mode register; starts on battery until supply qualifies
   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         mode_reg <= bms_pkg::BMS_BROWNOUT;
      end else begin
         mode_reg <= mode_next;
      end
   end

   // Power controls, registered from the next mode
   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         system_domain_enable  <= 1'b0;
         battery_supply_select <= 1'b1;
         pll_enable            <= 1'b1;
         mpu_run               <= 1'b1;
         display_enable        <= 1'b1;
      end else begin
         system_domain_enable  <= (mode_next == bms_pkg::BMS_MISSION);
         battery_supply_select <= (mode_next != bms_pkg::BMS_MISSION);
         // PLL also runs in low modes once supply returns, to relock
         pll_enable            <= (mode_next == bms_pkg::BMS_MISSION) ||
                                  (mode_next == bms_pkg::BMS_BROWNOUT) ||
                                  supply_good_flag;
         // Reset holds it high: MPU runs in both full modes
         mpu_run               <= (mode_next == bms_pkg::BMS_MISSION) ||
                                  (mode_next == bms_pkg::BMS_BROWNOUT);
         display_enable        <= (mode_next != bms_pkg::BMS_SLEEP);
      end
   end

   assign mode     = mode_reg;
   assign pll_fast = pll_fast_reg;

   // ==========================================================
   // APB slave
   assign setup_w = psel & ~penable;
   assign wr_w    = psel & penable & pready & pwrite;

   // Address decode and read data
   always_comb begin
      rd_value = 32'h0000_0000;
      mapped   = 1'b1;
      if (addr_is(paddr, bms_pkg::IDX_CLKCFG)) begin
         rd_value[bms_pkg::CLK_PLL_FAST_BIT] = pll_fast_reg;
      end else if (addr_is(paddr, bms_pkg::IDX_CTRL)) begin
         rd_value[bms_pkg::CTRL_DISP_BIT]  = disp_req_reg;
         rd_value[bms_pkg::CTRL_SLEEP_BIT] = sleep_req_reg;
      end else if (addr_is(paddr, bms_pkg::IDX_STATUS)) begin
         rd_value[bms_pkg::STAT_MODE_LSB +: 2] = mode_reg;
         rd_value[bms_pkg::STAT_GOOD_BIT]      = supply_good_flag;
         rd_value[bms_pkg::STAT_LOCK_BIT]      = pll_locked;
      end else if (addr_is(paddr, bms_pkg::IDX_WAKE)) begin
         rd_value[8:0] = wake_stat_reg;
      end else if (addr_is(paddr, bms_pkg::IDX_MASK)) begin
         rd_value[8:0] = mask_reg;
      end else begin
         mapped = 1'b0;
      end
   end

   // One wait-free access: answer ready in the first access cycle
   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         pready  <= 1'b0;
         pslverr <= 1'b0;
         prdata  <= 32'h0000_0000;
      end else begin
         pready  <= setup_w;
         pslverr <= setup_w & ~mapped;
         if (setup_w) begin
            prdata <= pwrite ? 32'h0000_0000 : rd_value;
         end
      end
   end

   // ==========================================================
   // Writable registers
   // Clock configuration; mode changes never touch it
   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         pll_fast_reg <= bms_pkg::CLK_PLL_FAST_RST;
      end else if (wr_w && addr_is(paddr, bms_pkg::IDX_CLKCFG)) begin
         pll_fast_reg <= pwdata[bms_pkg::CLK_PLL_FAST_BIT];
      end
   end

   // Mode requests; consumed on entry to the requested mode
   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         disp_req_reg  <= 1'b0;
         sleep_req_reg <= 1'b0;
      end else if (wr_w && addr_is(paddr, bms_pkg::IDX_CTRL)) begin
         disp_req_reg  <= pwdata[bms_pkg::CTRL_DISP_BIT];
         sleep_req_reg <= pwdata[bms_pkg::CTRL_SLEEP_BIT];
      end else begin
         if (mode_next == bms_pkg::BMS_DISPLAY && mode_reg != bms_pkg::BMS_DISPLAY) begin
            disp_req_reg <= 1'b0;
         end
         if (mode_next == bms_pkg::BMS_SLEEP && mode_reg != bms_pkg::BMS_SLEEP) begin
            sleep_req_reg <= 1'b0;
         end
      end
   end

   // Interrupt mask
   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         mask_reg <= bms_pkg::MASK_RST;
      end else if (wr_w && addr_is(paddr, bms_pkg::IDX_MASK)) begin
         mask_reg <= pwdata[8:0];
      end
   end

   // ==========================================================
   // Wake cause and interrupt
   // Wake sources count only when they end a low mode
   assign ev_w[bms_pkg::WAKE_W-1:0]    = (low_mode_w && !supply_good_flag) ?
                                         wake_events : 7'h00;
   assign ev_w[bms_pkg::EV_SUPPLY_LOST] = (mode_reg == bms_pkg::BMS_MISSION) &&
                                          (mode_next == bms_pkg::BMS_BROWNOUT);
   assign ev_w[bms_pkg::EV_SUPPLY_BACK] = (mode_reg != bms_pkg::BMS_MISSION) &&
                                          (mode_next == bms_pkg::BMS_MISSION);

   // Write one clears; a new event in the same cycle wins
   always_comb begin
      wake_stat_next = wake_stat_reg;
      if (wr_w && addr_is(paddr, bms_pkg::IDX_WAKE)) begin
         wake_stat_next = wake_stat_reg & ~pwdata[8:0];
      end
      wake_stat_next = wake_stat_next | ev_w;
   end

   // Sticky causes and level interrupt
   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         wake_stat_reg <= 9'h000;
         irq           <= 1'b0;
      end else begin
         wake_stat_reg <= wake_stat_next;
         irq           <= |(wake_stat_next & mask_reg);
      end
   end

   // ==========================================================
   // Checks
   a_forced_brownout: assert property (@(posedge sys_clk) disable iff (sys_rst)
      (mode_reg == bms_pkg::BMS_MISSION) && !supply_good_flag
      |=> (mode_reg == bms_pkg::BMS_BROWNOUT))
      else $error("mission kept without supply");

   a_mpu_runs: assert property (@(posedge sys_clk) disable iff (sys_rst)
      (mode_reg == bms_pkg::BMS_MISSION) ##1 (mode_reg == bms_pkg::BMS_BROWNOUT)
      |-> mpu_run && $past(mpu_run))
      else $error("MPU stopped across brownout entry");

   a_battery_res: assert property (@(posedge sys_clk) disable iff (sys_rst)
      (mode_reg == bms_pkg::BMS_BROWNOUT) && !$past(sys_rst)
      |-> !system_domain_enable && battery_supply_select)
      else $error("system domain live in brownout");

   a_pll_kept: assert property (@(posedge sys_clk) disable iff (sys_rst)
      (mode_reg == bms_pkg::BMS_MISSION) ##1 (mode_reg == bms_pkg::BMS_BROWNOUT)
      |-> pll_enable && $stable(pll_fast))
      else $error("PLL changed on brownout entry");

   a_supply_back: assert property (@(posedge sys_clk) disable iff (sys_rst)
      (mode_reg != bms_pkg::BMS_MISSION) && supply_good_flag && pll_locked
      |=> (mode_reg == bms_pkg::BMS_MISSION))
      else $error("no return to mission with supply");

   a_low_via_brn: assert property (@(posedge sys_clk) disable iff (sys_rst)
      (mode_reg == bms_pkg::BMS_SLEEP) && ($past(mode_reg) != bms_pkg::BMS_SLEEP)
      |-> ($past(mode_reg) == bms_pkg::BMS_BROWNOUT))
      else $error("sleep entered other than from brownout");

   a_wake_exit: assert property (@(posedge sys_clk) disable iff (sys_rst)
      low_mode_w && !supply_good_flag && (|wake_events)
      |=> (mode_reg == bms_pkg::BMS_BROWNOUT) ##0 (|wake_stat_reg))
      else $error("wake event did not reach brownout");

   a_brief_display: assert property (@(posedge sys_clk) disable iff (sys_rst)
      (mode_reg == bms_pkg::BMS_MISSION) && disp_req_reg && supply_good_flag &&
      pll_locked && !supply_below_threshold
      |=> (mode_reg == bms_pkg::BMS_DISPLAY) ##1 (mode_reg == bms_pkg::BMS_MISSION))
      else $error("display request in mission not brief");

endmodule : bms_sequencer

// ==== bms_supply_model.sv ====
// Far-side model: supply comparator and PLL lock for the sequencer
`timescale 1ns/1ps
module bms_supply_model #(
   parameter int LOCK_CYC = 20          // Lock delay in cycles, plain default
) (
   input  wire logic sys_clk,
   input  wire logic mains_on,
   output logic      supply_below_threshold,
   output logic      pll_locked
);
   // ==========================================================
   // State
   int   cnt_reg = 0;                   // Cycles since start, saturating

   // Comparator reports low supply while mains are away
   always @(posedge sys_clk) begin
      supply_below_threshold <= ~mains_on;
   end

   // PLL locks once, then keeps running on battery too
   always @(posedge sys_clk) begin
      if (cnt_reg < LOCK_CYC) begin
         cnt_reg <= cnt_reg + 1;
      end
      pll_locked <= (cnt_reg >= LOCK_CYC);
   end
endmodule : bms_supply_model

// ==== battery_mode_sequencer_bench.sv ====
// Testbench for the battery mode sequencer
`timescale 1ns/1ps
module battery_mode_sequencer_bench;
   // ==========================================================
   // Signals
   logic        sys_clk = 1'b0;         // 200 MHz clock
   logic        sys_rst = 1'b1;         // Synchronous reset
   logic        psel = 1'b0;            // APB select
   logic        penable = 1'b0;         // APB access phase
   logic        pwrite = 1'b0;          // APB direction
   logic [15:0] paddr = 16'h0000;       // APB byte address
   logic [31:0] pwdata = 32'h0;         // APB write data
   logic [31:0] prdata;                 // APB read data
   logic        pready, pslverr;        // APB answer
   logic        mains_on = 1'b0;        // Mains present
   logic        sbt, lock;              // Comparator and PLL lock
   logic [6:0]  wk = 7'h60;             // Wake sources, receive lines idle high
   logic [1:0]  mode;                   // Current mode
   logic        sde, bss, pen, pfast, run, den, irq; // Power controls
   logic [31:0] rd;                     // Last read data
   logic        er;                     // Last slave error
   logic        saw;                    // Display blip seen
   int          fails = 0;              // Mismatch count
   int          n_tests = 0;            // Comparison count

   always #2.5 sys_clk = ~sys_clk;

   bms_supply_model model (.sys_clk(sys_clk), .mains_on(mains_on),
      .supply_below_threshold(sbt), .pll_locked(lock));

   bms_sequencer uut (.sys_clk(sys_clk), .sys_rst(sys_rst), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .supply_below_threshold(sbt), .pll_locked(lock), .wake_timer_expired(wk[0]),
      .pushbutton_input(wk[1]), .wake_pin_a(wk[2]), .wake_pin_b(wk[3]),
      .wake_pin_c(wk[4]), .serial_rx_pin(wk[5]), .optical_receive_pin(wk[6]),
      .mode(mode), .system_domain_enable(sde), .battery_supply_select(bss),
      .pll_enable(pen), .pll_fast(pfast), .mpu_run(run), .display_enable(den),
      .irq(irq));

   // ==========================================================
   // Tasks
   task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      n_tests++;
      if (seen !== exp) begin
         fails++;
         $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
      end
   endtask : check

   // One APB transfer, held until pready is sampled high
   task automatic apb(input logic wr, input logic [13:0] idx, input logic [31:0] wd);
      int n;
      n = 0;
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= {idx, 2'b00};
      pwdata <= wd;
      @(posedge sys_clk);
      penable <= 1'b1;
      do begin
         @(posedge sys_clk);
         n++;
      end while (pready !== 1'b1 && n < 50);
      // A slave that never answers counts as a mismatch
      if (pready !== 1'b1) fails++;
      rd = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge sys_clk);
   endtask : apb

   // Waits a bounded time for a mode, then compares
   task automatic wait_mode(input logic [1:0] m);
      int n;
      n = 0;
      while (mode !== m && n < 400) begin
         @(posedge sys_clk);
         n++;
      end
      check("mode", mode, m);
   endtask : wait_mode

   task automatic give_verdict();
      $display("Comparisons %0d mismatches %0d", n_tests, fails);
      if (fails == 0 && n_tests > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask : give_verdict

   // ==========================================================
   // Watchdog
   initial begin
      repeat (20000) @(posedge sys_clk);
      fails++;
      give_verdict();
   end

   // ==========================================================
   // Main sequence
   initial begin
      repeat (12) @(posedge sys_clk);
      sys_rst <= 1'b0;
      @(posedge sys_clk);
      check("mode", mode, 2'h1);
      apb(1'b0, bms_pkg::IDX_CLKCFG, 32'h0);
      check("clkcfg", rd, 32'h1);
      apb(1'b0, bms_pkg::IDX_MASK, 32'h0);
      check("mask", rd, 32'h0);
      apb(1'b0, 14'h0000, 32'h0);
      check("pslverr", er, 1'h1);
      mains_on <= 1'b1;
      wait_mode(2'h0);
      check("sys_dom", sde, 1'h1);
      apb(1'b0, bms_pkg::IDX_STATUS, 32'h0);
      check("status", rd, 32'hc);
      apb(1'b1, bms_pkg::IDX_MASK, 32'h1ff);
      apb(1'b1, bms_pkg::IDX_CTRL, 32'h40);
      saw = 1'b0;
      repeat (8) begin
         @(posedge sys_clk);
         if (mode === 2'h2) saw = 1'b1;
      end
      check("blip", saw, 1'h1);
      check("mode", mode, 2'h0);
      apb(1'b1, bms_pkg::IDX_WAKE, 32'h1ff);
      // Mains lost: forced brownout with the MPU still running
      mains_on <= 1'b0;
      wait_mode(2'h1);
      check("sys_dom", sde, 1'h0);
      check("battery", bss, 1'h1);
      check("mpu_run", run, 1'h1);
      check("pll_en", pen, 1'h1);
      check("pll_fast", pfast, 1'h1);
      // Firmware may slow the PLL itself in brownout
      apb(1'b1, bms_pkg::IDX_CLKCFG, 32'h0);
      check("pll_fast", pfast, 1'h0);
      apb(1'b0, bms_pkg::IDX_STATUS, 32'h0);
      check("status", rd, 32'h9);
      apb(1'b0, bms_pkg::IDX_WAKE, 32'h0);
      check("wake", rd, 32'h80);
      check("irq", irq, 1'h1);
      apb(1'b1, bms_pkg::IDX_WAKE, 32'h1ff);
      apb(1'b1, bms_pkg::IDX_MASK, 32'h0);
      check("irq", irq, 1'h0);
      // Every wake source from display-only or sleep
      for (int i = 0; i < 7; i++) begin
         apb(1'b1, bms_pkg::IDX_CTRL, (i % 2) ? 32'h80 : 32'h40);
         wait_mode((i % 2) ? 2'h3 : 2'h2);
         check("disp_en", den, (i % 2) ? 32'h0 : 32'h1);
         wk[i] <= ~wk[i];
         @(posedge sys_clk);
         wk[i] <= ~wk[i];
         wait_mode(2'h1);
         apb(1'b0, bms_pkg::IDX_WAKE, 32'h0);
         check("wake", rd, 32'h1 << i);
         check("irq_masked", irq, 1'h0);
         apb(1'b1, bms_pkg::IDX_WAKE, 32'h1ff);
      end
      // Mains back while asleep
      apb(1'b1, bms_pkg::IDX_CTRL, 32'h80);
      wait_mode(2'h3);
      mains_on <= 1'b1;
      wait_mode(2'h0);
      check("mpu_run", run, 1'h1);
      apb(1'b0, bms_pkg::IDX_WAKE, 32'h0);
      check("back", rd[8], 1'h1);
      // sys_rst asserted again after the return to mission
      sys_rst <= 1'b1;
      repeat (2) @(posedge sys_clk);
      sys_rst <= 1'b0;
      @(posedge sys_clk);
      check("mode", mode, 2'h1);
      apb(1'b0, bms_pkg::IDX_CLKCFG, 32'h0);
      check("clkcfg", rd, 32'h1);
      apb(1'b0, bms_pkg::IDX_WAKE, 32'h0);
      check("wake", rd, 32'h0);
      wait_mode(2'h0);
      check("mpu_run", run, 1'h1);
      give_verdict();
   end
endmodule : battery_mode_sequencer_bench
